// File: src/wdg_top.sv
// Watchdog timer with reset-cause flags behind an APB slave
`timescale 1ns/1ns
`include "wdg_defines.svh"

module wdg_top (
    // APB clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Watchdog oscillator
    input  wire logic        wdog_osc,
    // Other reset sources, active high
    input  wire logic        pin_reset_active,
    input  wire logic        brownout_active,
    // Fuses, high when programmed
    input  wire logic        always_on_fuse,
    input  wire logic        compat_fuse,
    // To the system reset logic
    output logic             dog_reset_pulse,
    output logic             dog_running
);

    // Synchronised inputs
    logic [4:0]           sync_vec;
    logic                 osc_s;
    logic                 pin_s;
    logic                 bod_s;
    logic                 ao_fuse_s;
    logic                 compat_fuse_s;
    logic                 osc_d_reg;
    logic                 osc_tick;

    // Configuration and state
    wdg_pkg::wdg_level_e  level;
    logic                 chip_reset;
    logic                 dog_on_reg;
    logic                 dog_on_eff;
    logic [2:0]           period_sel_reg;
    logic [2:0]           unlock_cnt_reg;
    logic                 unlock_live;
    logic [3:0]           flags_reg;
    wdg_pkg::wdg_count_t  count_reg;
    wdg_pkg::wdg_count_t  period_limit;
    logic                 expire;

    // Bus decode
    logic                 setup_ph;
    logic                 wr_acc;
    logic                 wr_flags;
    logic                 wr_ctrl;
    logic                 wr_restart;
    logic                 addr_hit;
    logic [7:0]           ctrl_rd;
    logic [31:0]          rd_mux;
    logic [7:0]           wbyte;

    wdg_sync #(
        .W (5)
    ) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in ({compat_fuse, always_on_fuse, brownout_active, pin_reset_active, wdog_osc}),
        .sync_out (sync_vec)
    );

    assign osc_s         = sync_vec[0];
    assign pin_s         = sync_vec[1];
    assign bod_s         = sync_vec[2];
    assign ao_fuse_s     = sync_vec[3];
    assign compat_fuse_s = sync_vec[4];

    // Oscillator edge detect; osc runs far slower than pclk
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_d_reg <= 1'b0;
        end else begin
            osc_d_reg <= osc_s;
        end
    end

    assign osc_tick = osc_s & ~osc_d_reg;

    // Safety level from the fuses
    always_comb begin
        if (ao_fuse_s) begin
            level = wdg_pkg::WDG_LVL2;
        end else if (compat_fuse_s) begin
            level = wdg_pkg::WDG_LVL0;
        end else begin
            level = wdg_pkg::WDG_LVL1;
        end
    end

    // Any chip reset other than power-on
    assign chip_reset = pin_s | bod_s | dog_reset_pulse;

    // Level 2 forces the watchdog on regardless of the stored bit
    assign dog_on_eff  = dog_on_reg | (level == wdg_pkg::WDG_LVL2);
    assign dog_running = dog_on_eff;
    assign unlock_live = (unlock_cnt_reg != 3'h0);

    // APB decode; zero wait states
    assign pready     = 1'b1;
    assign setup_ph   = psel & ~penable;
    assign wr_acc     = psel & penable & pwrite;
    assign wbyte      = pwdata[7:0];
    assign wr_flags   = wr_acc & (paddr == `WDG_OFS_FLAGS);
    assign wr_ctrl    = wr_acc & (paddr == `WDG_OFS_CTRL);
    assign wr_restart = wr_acc & (paddr == `WDG_OFS_RESTART);

    always_comb begin
        addr_hit = (paddr == `WDG_OFS_FLAGS) || (paddr == `WDG_OFS_CTRL) ||
                   (paddr == `WDG_OFS_RESTART) || (paddr == `WDG_OFS_STATUS) ||
                   (paddr == `WDG_OFS_COUNT);
    end

    // Unlock window counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unlock_cnt_reg <= 3'h0;
        end else if (chip_reset) begin
            unlock_cnt_reg <= 3'h0;
        end else if (wr_ctrl && wbyte[`WDG_BIT_UNLOCK] && wbyte[`WDG_BIT_ON]) begin
            unlock_cnt_reg <= `WDG_UNLOCK_CYCLES;
        end else if (unlock_live) begin
            unlock_cnt_reg <= unlock_cnt_reg - 3'h1;
        end
    end

    // Enable bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dog_on_reg <= 1'b0;
        end else if (chip_reset) begin
            dog_on_reg <= 1'b0;
        end else if (wr_ctrl) begin
            if (wbyte[`WDG_BIT_ON]) begin
                dog_on_reg <= 1'b1;
            end else if (unlock_live && level != wdg_pkg::WDG_LVL2) begin
                dog_on_reg <= 1'b0;
            end
        end
    end

    // Prescaler; protected at levels 1 and 2
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_sel_reg <= `WDG_PSEL_RST;
        end else if (chip_reset) begin
            period_sel_reg <= `WDG_PSEL_RST;
        end else if (wr_ctrl) begin
            if (level == wdg_pkg::WDG_LVL0 || unlock_live) begin
                period_sel_reg <= wbyte[`WDG_PSEL_MSB:`WDG_PSEL_LSB];
            end
        end
    end

    // Time-out length in oscillator cycles
    assign period_limit = `WDG_BASE_CYCLES << period_sel_reg;
    assign expire = dog_on_eff & osc_tick & (count_reg == period_limit - 22'h000001);

    // Watchdog counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= '0;
        end else if (chip_reset || wr_restart || !dog_on_eff) begin
            count_reg <= '0;
        end else if (expire) begin
            count_reg <= '0;
        end else if (osc_tick) begin
            count_reg <= count_reg + 22'h000001;
        end
    end

    // One-clock reset pulse; its fall starts the external start-up delay
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dog_reset_pulse <= 1'b0;
        end else begin
            dog_reset_pulse <= expire & ~dog_reset_pulse;
        end
    end

    // Reset-cause flags; hardware set wins over software clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_reg <= `WDG_FLAGS_RST;
        end else begin
            if (dog_reset_pulse) begin
                flags_reg[`WDG_BIT_DOG_SEEN] <= 1'b1;
            end else if (wr_flags && !wbyte[`WDG_BIT_DOG_SEEN]) begin
                flags_reg[`WDG_BIT_DOG_SEEN] <= 1'b0;
            end
            if (bod_s) begin
                flags_reg[`WDG_BIT_BOD_SEEN] <= 1'b1;
            end else if (wr_flags && !wbyte[`WDG_BIT_BOD_SEEN]) begin
                flags_reg[`WDG_BIT_BOD_SEEN] <= 1'b0;
            end
            if (pin_s) begin
                flags_reg[`WDG_BIT_PIN_SEEN] <= 1'b1;
            end else if (wr_flags && !wbyte[`WDG_BIT_PIN_SEEN]) begin
                flags_reg[`WDG_BIT_PIN_SEEN] <= 1'b0;
            end
            if (wr_flags && !wbyte[`WDG_BIT_POR_SEEN]) begin
                flags_reg[`WDG_BIT_POR_SEEN] <= 1'b0;
            end
        end
    end

    // Control readback
    always_comb begin
        ctrl_rd = 8'h00;
        ctrl_rd[`WDG_BIT_UNLOCK] = unlock_live;
        ctrl_rd[`WDG_BIT_ON] = dog_on_eff;
        ctrl_rd[`WDG_PSEL_MSB:`WDG_PSEL_LSB] = period_sel_reg;
    end

    // Read multiplexer
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            `WDG_OFS_FLAGS: begin
                rd_mux[3:0] = flags_reg;
            end
            `WDG_OFS_CTRL: begin
                rd_mux[7:0] = ctrl_rd;
            end
            `WDG_OFS_STATUS: begin
                rd_mux[`WDG_STAT_LVL_MSB:`WDG_STAT_LVL_LSB] = level;
                rd_mux[`WDG_STAT_RUN] = dog_on_eff;
                rd_mux[`WDG_STAT_OPEN] = unlock_live;
            end
            `WDG_OFS_COUNT: begin
                rd_mux[21:0] = count_reg;
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    // Read data sampled in setup so it comes from a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup_ph) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_mux;
        end
    end

    // Error answer for unmapped addresses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else if (setup_ph) begin
            pslverr <= ~addr_hit;
        end
    end

endmodule : wdg_top

// File: common/wdg_defines.svh
// Offsets, field positions, reset values and timing counts of the watchdog block
`ifndef WDG_DEFINES_SVH
`define WDG_DEFINES_SVH

// Register byte offsets
`define WDG_OFS_FLAGS       12'h000
`define WDG_OFS_CTRL        12'h004
`define WDG_OFS_RESTART     12'h008
`define WDG_OFS_STATUS      12'h00c
`define WDG_OFS_COUNT       12'h010

// reset_cause_flags fields
`define WDG_BIT_DOG_SEEN    3
`define WDG_BIT_BOD_SEEN    2
`define WDG_BIT_PIN_SEEN    1
`define WDG_BIT_POR_SEEN    0
`define WDG_FLAGS_RST       4'h1

// watchdog_control fields
`define WDG_BIT_UNLOCK      4
`define WDG_BIT_ON          3
`define WDG_PSEL_MSB        2
`define WDG_PSEL_LSB        0
`define WDG_PSEL_RST        3'h0

// status fields
`define WDG_STAT_LVL_MSB    1
`define WDG_STAT_LVL_LSB    0
`define WDG_STAT_RUN        2
`define WDG_STAT_OPEN       3

// Timing
`define WDG_PCLK_HZ         100000000
`define WDG_OSC_HZ          1000000
`define WDG_UNLOCK_CYCLES   3'h4
`define WDG_BASE_CYCLES     22'h004000

`endif

// File: common/wdg_pkg.sv
// Types shared by the watchdog block
package wdg_pkg;

    typedef enum logic [1:0] {
        WDG_LVL0 = 2'b00,
        WDG_LVL1 = 2'b01,
        WDG_LVL2 = 2'b10
    } wdg_level_e;

    typedef logic [21:0] wdg_count_t;

endpackage : wdg_pkg

// File: src/wdg_sync.sv
// Two-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/1ns
module wdg_sync #(
    parameter int W = 5
) (
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Data
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta_reg;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            // First stage feeds only the second
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    meta_reg[i] <= 1'b0;
                    sync_out[i] <= 1'b0;
                end else begin
                    meta_reg[i] <= async_in[i];
                    sync_out[i] <= meta_reg[i];
                end
            end
        end
    endgenerate

endmodule : wdg_sync

// File: tb/wdg_props.sv
// Port-level assertions of the watchdog block
`timescale 1ns/1ns
`include "wdg_defines.svh"
module wdg_props (
    // Clock, reset and bus
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Watchdog side
    input wire logic        always_on_fuse,
    input wire logic        dog_reset_pulse,
    input wire logic        dog_running
);
    logic acc;
    assign acc = psel && penable;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    pulse_one_a: assert property (dog_reset_pulse |=> !dog_reset_pulse) else $error("pulse too long");
    pulse_cause_a: assert property ($rose(dog_reset_pulse) |-> $past(dog_running)) else $error("pulse while off");
    stop_after_a: assert property (dog_reset_pulse && !always_on_fuse |-> ##[1:2] !dog_running)
        else $error("still running after pulse");
    enable_wr_a: assert property (acc && pwrite && paddr == `WDG_OFS_CTRL && pwdata[3] |=> dog_running)
        else $error("enable write lost");
    // Fuse sync takes a few edges, so wait three
    level_two_a: assert property (always_on_fuse && $past(presetn, 3) |-> dog_running)
        else $error("level 2 stopped");
    reserved_a: assert property (acc && !pwrite && paddr == `WDG_OFS_CTRL |-> prdata[31:5] == 27'h0)
        else $error("reserved bits set");
    unmapped_a: assert property (acc && paddr > `WDG_OFS_COUNT |-> pslverr) else $error("no slave error");
    ready_a: assert property (acc |-> pready) else $error("no ready");
    cover property (dog_reset_pulse);
    cover property (acc && pslverr);
    cover property (acc && pwrite && paddr == `WDG_OFS_CTRL && pwdata[4]);
endmodule : wdg_props

bind wdg_top wdg_props wdg_props_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .always_on_fuse(always_on_fuse), .dog_reset_pulse(dog_reset_pulse), .dog_running(dog_running));

// File: tb/tb_top.sv
// Self-checking bench of the watchdog block
`timescale 1ns/1ns
`include "wdg_defines.svh"
module tb_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, wdog_osc;
    logic        pin_reset_active, brownout_active, always_on_fuse, compat_fuse, dog_reset_pulse, dog_running;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    int          miscompares, checks_done, n;
    // Rows: address, written byte, expected read back
    logic [27:0] rows [6];

    wdg_top wdg_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .wdog_osc(wdog_osc), .pin_reset_active(pin_reset_active), .brownout_active(brownout_active),
        .always_on_fuse(always_on_fuse), .compat_fuse(compat_fuse), .dog_reset_pulse(dog_reset_pulse),
        .dog_running(dog_running));

    always #5 pclk = ~pclk;
    // Oscillator at pclk/4, offset so edges never meet pclk edges
    initial begin
        wdog_osc = 1'b0;
        #3;
        forever #20 wdog_osc = ~wdog_osc;
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check

    task summarize();
        $display("checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : summarize

    task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int k;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            miscompares++;
            $display("ERROR %0t: no ready", $time);
            summarize();
        end else begin
            rdata   = prdata;
            err     = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask : apb

    task wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 8'h00);
        check(rdata, exp);
    endtask : rd

    // Fuses change only under reset, as on a real part
    task do_reset(input logic ao, input logic cf);
        presetn        <= 1'b0;
        always_on_fuse <= ao;
        compat_fuse    <= cf;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
    endtask : do_reset

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {pin_reset_active, brownout_active, always_on_fuse, compat_fuse} = 4'h0;
        miscompares = 0;
        checks_done = 0;
        rows[0] = {`WDG_OFS_CTRL, 8'h08, 8'h08};
        rows[1] = {`WDG_OFS_CTRL, 8'h00, 8'h08};
        rows[2] = {`WDG_OFS_CTRL, 8'he2, 8'h08};
        rows[3] = {`WDG_OFS_FLAGS, 8'h0f, 8'h01};
        rows[4] = {`WDG_OFS_FLAGS, 8'h00, 8'h00};
        rows[5] = {`WDG_OFS_RESTART, 8'h55, 8'h00};
        do_reset(1'b0, 1'b0);
        rd(`WDG_OFS_FLAGS, 32'h1);
        rd(`WDG_OFS_STATUS, 32'h1);
        apb(1'b0, 12'h020, 8'h00);
        check({31'h0, err}, 32'h1);
        $display("done reset");
        for (int i = 0; i < 6; i++) begin
            wr(rows[i][27:16], rows[i][15:8]);
            rd(rows[i][27:16], {24'h0, rows[i][7:0]});
        end
        $display("done table");
        // Back-to-back unlock, disable and period change
        wr(`WDG_OFS_CTRL, 8'h18);
        wr(`WDG_OFS_CTRL, 8'h05);
        rd(`WDG_OFS_CTRL, 32'h5);
        rd(`WDG_OFS_COUNT, 32'h0);
        wr(`WDG_OFS_CTRL, 8'h08);
        wr(`WDG_OFS_CTRL, 8'h18);
        rd(`WDG_OFS_CTRL, 32'h1d);
        wr(`WDG_OFS_CTRL, 8'h00);
        rd(`WDG_OFS_CTRL, 32'hd);
        $display("done unlock");
        for (int i = 0; i < 2; i++) begin
            pin_reset_active <= (i == 0);
            brownout_active  <= (i == 1);
            repeat (4) @(posedge pclk);
            pin_reset_active <= 1'b0;
            brownout_active  <= 1'b0;
            repeat (3) @(posedge pclk);
            rd(`WDG_OFS_FLAGS, (i == 0) ? 32'h2 : 32'h6);
            rd(`WDG_OFS_CTRL, 32'h0);
        end
        do_reset(1'b1, 1'b0);
        rd(`WDG_OFS_FLAGS, 32'h1);
        rd(`WDG_OFS_STATUS, 32'h6);
        check({31'h0, dog_running}, 32'h1);
        wr(`WDG_OFS_CTRL, 8'h04);
        rd(`WDG_OFS_CTRL, 32'h8);
        wr(`WDG_OFS_CTRL, 8'h18);
        wr(`WDG_OFS_CTRL, 8'h03);
        rd(`WDG_OFS_CTRL, 32'hb);
        $display("done level 2");
        do_reset(1'b0, 1'b1);
        rd(`WDG_OFS_STATUS, 32'h0);
        wr(`WDG_OFS_CTRL, 8'h06);
        rd(`WDG_OFS_CTRL, 32'h6);
        wr(`WDG_OFS_CTRL, 8'h08);
        // Let the counter run first, so a lost restart shortens the time-out
        repeat (2000) @(posedge pclk);
        check({31'h0, dog_running}, 32'h1);
        wr(`WDG_OFS_RESTART, 8'h00);
        n = 0;
        while (dog_reset_pulse !== 1'b1 && n < 70000) begin
            @(posedge pclk);
            #1;
            n++;
        end
        check({31'h0, n > 65520 && n < 65560}, 32'h1);
        @(posedge pclk);
        #1;
        check({31'h0, dog_reset_pulse}, 32'h0);
        rd(`WDG_OFS_FLAGS, 32'h9);
        rd(`WDG_OFS_CTRL, 32'h0);
        check({31'h0, dog_running}, 32'h0);
        $display("done timeout");
        summarize();
    end
endmodule : tb_top
